// ===== drc_ctrl.sv
// module: dram controller start, fault address capture and refresh scheduling
`default_nettype none
module drc_ctrl #(
  parameter int ADDR_W = 24
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  // peripheral register port
  input wire logic REG_PORT_SELECT_N,
  input wire logic REG_WRITE,
  input wire logic [3:0] REG_INDEX,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  // memory request side
  input wire logic MEM_REQ_N,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_FAULT_EVENT,
  output logic MEM_ACK_N,
  output logic FAULT_N,
  // dram controls, sharing the one enable DRAM_CTL_OE
  output logic RAS_N,
  output logic CAS_N,
  output logic WRITE_EN_N,
  output logic READ_EN_N,
  output logic DRAM_CTL_OE
);
  // ****************
  // pin synchronisers
  // ****************
  logic [1:0] sel_sync;
  logic [1:0] req_sync;
  logic [1:0] flt_sync;
  logic [1:0] next_sel_sync;
  logic [1:0] next_req_sync;
  logic [1:0] next_flt_sync;

  always_comb begin
    next_sel_sync = {sel_sync[0], ~REG_PORT_SELECT_N};
    next_req_sync = {req_sync[0], ~MEM_REQ_N};
    next_flt_sync = {flt_sync[0], MEM_FAULT_EVENT};
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sel_sync <= 2'h0;
      req_sync <= 2'h0;
      flt_sync <= 2'h0;
    end else begin
      sel_sync <= next_sel_sync;
      req_sync <= next_req_sync;
      flt_sync <= next_flt_sync;
    end
  end

  logic sel;
  logic req;
  logic fault_now;
  logic sel_d;
  assign sel = sel_sync[1];
  assign req = req_sync[1];
  assign fault_now = flt_sync[1];

  // ****************
  // register file
  // ****************
  logic run;
  logic fault_flag;
  logic [7:0] refresh_interval;
  logic [7:0] fault_addr [3];
  logic [7:0] rdata;
  logic next_run;
  logic next_fault_flag;
  logic [7:0] next_refresh_interval;
  logic [7:0] next_fault_addr [3];
  logic [7:0] next_rdata;
  logic next_sel_d;
  logic wr_stb;
  logic rd_stb;
  logic fault_out;
  logic next_fault_out;
  logic fault_rise;

  // one access per select assertion
  assign wr_stb = sel && !sel_d && REG_WRITE;
  assign rd_stb = sel && !sel_d && !REG_WRITE;
  // a held fault event captures once, on its first synced cycle
  assign fault_rise = fault_now && !fault_out;

  always_comb begin
    next_run = run;
    next_fault_flag = fault_flag;
    next_refresh_interval = refresh_interval;
    next_fault_addr = fault_addr;
    next_rdata = rdata;
    next_sel_d = sel;
    next_fault_out = fault_now;
    if (wr_stb) begin
      unique case (REG_INDEX)
        drc_pkg::REG_RUN_CONTROL: next_run = DATA_IN[drc_pkg::RUN_BIT];
        drc_pkg::REG_FAULT_FLAG: next_fault_flag = DATA_IN[drc_pkg::FAULT_FLAG_BIT];
        drc_pkg::REG_REFRESH_INTERVAL: next_refresh_interval = DATA_IN;
        default: next_run = run;
      endcase
    end
    if (fault_rise) begin
      next_fault_flag = 1'b1;
      next_fault_addr[0] = MEM_ADDR[7:0];
      next_fault_addr[1] = MEM_ADDR[15:8];
      next_fault_addr[2] = MEM_ADDR[23:16];
    end
    if (rd_stb) begin
      unique case (REG_INDEX)
        drc_pkg::REG_RUN_CONTROL: next_rdata = {drc_pkg::RUN_UPPER_READ, run};
        drc_pkg::REG_FAULT_FLAG: next_rdata = {fault_flag, 7'h00};
        drc_pkg::REG_FAULT_ADDR0: next_rdata = fault_addr[0];
        drc_pkg::REG_FAULT_ADDR1: next_rdata = fault_addr[1];
        drc_pkg::REG_FAULT_ADDR2: next_rdata = fault_addr[2];
        drc_pkg::REG_REFRESH_INTERVAL: next_rdata = refresh_interval;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      run <= drc_pkg::RUN_RESET;
      fault_flag <= 1'b0;
      refresh_interval <= drc_pkg::REFRESH_RESET;
      fault_addr[0] <= drc_pkg::FAULT_ADDR_RESET;
      fault_addr[1] <= drc_pkg::FAULT_ADDR_RESET;
      fault_addr[2] <= drc_pkg::FAULT_ADDR_RESET;
      rdata <= 8'h00;
      sel_d <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      run <= next_run;
      fault_flag <= next_fault_flag;
      refresh_interval <= next_refresh_interval;
      fault_addr <= next_fault_addr;
      rdata <= next_rdata;
      sel_d <= next_sel_d;
      fault_out <= next_fault_out;
    end
  end

  // read data driven while the port is selected for a read
  assign DATA_OUT = rdata;
  assign DATA_OE = sel && sel_d && !REG_WRITE;
  // registered so the pin asserts on the edge that latches the address
  assign FAULT_N = ~fault_out;

  // ****************
  // refresh timer
  // ****************
  logic refresh_due;
  logic refresh_done;

  drc_refresh_timer #(
    .COUNT_W(drc_pkg::REFRESH_COUNT_W)
  ) drc_refresh_timer_inst (
    .clock(CLOCK),
    .rstn(RSTN),
    .run(run),
    .interval(refresh_interval),
    .reload(refresh_done),
    .due(refresh_due)
  );

  // ****************
  // access sequencer
  // ****************
  drc_pkg::drc_state_e state;
  drc_pkg::drc_state_e next_state;
  drc_pkg::drc_dram_ctl_s ctl;
  drc_pkg::drc_dram_ctl_s next_ctl;
  logic ack;
  logic next_ack;

  assign refresh_done = (state == drc_pkg::DRC_REFRESH);

  always_comb begin
    next_state = state;
    next_ctl = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
    next_ack = 1'b0;
    unique case (state)
      drc_pkg::DRC_IDLE: begin
        if (!run) begin
          next_state = drc_pkg::DRC_IDLE;
        end else if (refresh_due) begin
          next_state = drc_pkg::DRC_REFRESH;
          next_ctl.cas_n = 1'b0;
          next_ctl.ras_n = 1'b0;
        end else if (req && !ack) begin
          next_state = drc_pkg::DRC_ACCESS;
          next_ctl.ras_n = 1'b0;
          next_ctl.cas_n = 1'b0;
          next_ctl.oe_n = 1'b0;
        end
      end
      drc_pkg::DRC_ACCESS: begin
        next_state = drc_pkg::DRC_IDLE;
        next_ack = 1'b1;
      end
      drc_pkg::DRC_REFRESH: begin
        next_state = drc_pkg::DRC_IDLE;
      end
      default: next_state = drc_pkg::DRC_IDLE;
    endcase
    // ack holds until the request is withdrawn or run clears
    if (ack && req && run) begin
      next_ack = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= drc_pkg::DRC_IDLE;
      ctl <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      ack <= 1'b0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      ack <= next_ack;
    end
  end

  // strobes read idle at once when run clears mid refresh
  assign RAS_N = ctl.ras_n || !run;
  assign CAS_N = ctl.cas_n || !run;
  assign WRITE_EN_N = ctl.we_n;
  assign READ_EN_N = ctl.oe_n;
  assign DRAM_CTL_OE = run;
  assign MEM_ACK_N = ~(ack && run);
endmodule
`default_nettype wire

// ===== drc_pkg.sv
// package: register map, field layout, reset values and carriers for the dram control block
`default_nettype none
package drc_pkg;
  // register indices on the peripheral port (address lines pick one)
  localparam logic [3:0] REG_FAULT_FLAG = 4'h6;
  localparam logic [3:0] REG_RUN_CONTROL = 4'h7;
  localparam logic [3:0] REG_FAULT_ADDR0 = 4'h8;
  localparam logic [3:0] REG_FAULT_ADDR1 = 4'h9;
  localparam logic [3:0] REG_FAULT_ADDR2 = 4'ha;
  localparam logic [3:0] REG_REFRESH_INTERVAL = 4'hb;
  // field positions
  localparam int RUN_BIT = 0;
  localparam int FAULT_FLAG_BIT = 7;
  // reset values
  localparam logic RUN_RESET = 1'b0;
  localparam logic [7:0] REFRESH_RESET = 8'h00;
  localparam logic [7:0] FAULT_ADDR_RESET = 8'h00;
  // undefined upper bits of run_control read back as this pattern
  localparam logic [6:0] RUN_UPPER_READ = 7'h00;
  // refresh interval scale: shift giving four cycles per interval step
  localparam int REFRESH_SCALE_SHIFT = 2;
  localparam int REFRESH_COUNT_W = 10;

  typedef enum logic [1:0] {
    DRC_IDLE = 2'b00,
    DRC_ACCESS = 2'b01,
    DRC_REFRESH = 2'b10
  } drc_state_e;

  // peripheral register access request
  typedef struct packed {
    logic sel;
    logic write;
    logic [3:0] index;
    logic [7:0] wdata;
  } drc_reg_req_s;

  // dram control outputs with enables (active low levels)
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
  } drc_dram_ctl_s;
endpackage
`default_nettype wire

// ===== drc_refresh_timer.sv
// module: refresh interval timer, interval given in steps of four cycles
`default_nettype none
module drc_refresh_timer #(
  parameter int COUNT_W = drc_pkg::REFRESH_COUNT_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic [7:0] interval,
  input wire logic reload,
  output logic due
);
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [COUNT_W-1:0] span;

  always_comb begin
    span = COUNT_W'(interval) << drc_pkg::REFRESH_SCALE_SHIFT;
    next_count = count;
    if (!run) begin
      next_count = '0;
    end else if (reload) begin
      next_count = '0;
    end else if (!due) begin
      next_count = count + COUNT_W'(1);
    end
  end

  // zero interval never requests refresh
  assign due = run && (span != '0) && (count >= span - COUNT_W'(1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ===== drc_ctrl_assertions.sv
// checker: port properties of the dram control block
`default_nettype none
module drc_ctrl_checker (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic REG_PORT_SELECT_N,
  input wire logic REG_WRITE,
  input wire logic DATA_OE,
  input wire logic MEM_REQ_N,
  input wire logic MEM_FAULT_EVENT,
  input wire logic MEM_ACK_N,
  input wire logic FAULT_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WRITE_EN_N,
  input wire logic READ_EN_N,
  input wire logic DRAM_CTL_OE
);
  logic rfsh;
  assign rfsh = !RAS_N && !CAS_N && READ_EN_N && WRITE_EN_N;
  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  reset_quiet_a: assert property ($rose(RSTN) |-> !DRAM_CTL_OE)
    else $error("controls driven after reset");
  quiet_strobe_a: assert property (!DRAM_CTL_OE |-> RAS_N && CAS_N)
    else $error("strobe while quiet");
  quiet_no_ack_a: assert property (!DRAM_CTL_OE |-> MEM_ACK_N)
    else $error("ack while quiet");
  read_answer_a: assert property ($rose(DATA_OE) |-> !REG_WRITE && !$past(REG_PORT_SELECT_N, 2))
    else $error("data driven without read select");
  ack_after_strobe_a: assert property ($fell(MEM_ACK_N) |-> !$past(RAS_N) && !$past(CAS_N))
    else $error("ack without strobes");
  ack_release_a: assert property ($rose(MEM_ACK_N) |-> $past(MEM_REQ_N, 3))
    else $error("ack dropped while requested");
  fault_follow_a: assert property ($rose(MEM_FAULT_EVENT) |-> ##[1:4] !FAULT_N)
    else $error("fault output late");
  refresh_single_a: assert property (rfsh |=> RAS_N && CAS_N)
    else $error("refresh longer than one cycle");
  cover property ($fell(MEM_ACK_N));
  cover property (rfsh);
  cover property ($fell(FAULT_N));
endmodule
`default_nettype wire

// ===== drc_dram_model.sv
// model: dram array side, counts refreshes and their spacing
`default_nettype none
module drc_dram_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic oe_n,
  output logic [7:0] count,
  output logic [7:0] gap
);
  logic [7:0] since;
  logic rfsh;
  assign rfsh = !ras_n && !cas_n && oe_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
      gap <= 8'h00;
      since <= 8'h00;
    end else if (rfsh) begin
      count <= count + 8'h01;
      gap <= since + 8'h01;
      since <= 8'h00;
    end else begin
      since <= since + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test_drc_ctrl.sv
// testbench: register, memory, refresh and fault sequences
`default_nettype none
module test_drc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RI = 8'h02;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sel_n = 1'b1;
  logic wr = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [7:0] din = 8'h00;
  logic req_n = 1'b1;
  logic [23:0] addr = 24'h5a3c71;
  logic ev = 1'b0;
  logic [7:0] dout, rd, cnt, gap, c0;
  logic doe, ack_n, flt_n, ras_n, cas_n, we_n, re_n, oe;
  int fails = 0;
  int checks = 0;
  int k;
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
  always #10 clk = ~clk;
  drc_ctrl drc_ctrl_inst (.CLOCK(clk), .RSTN(rstn), .REG_PORT_SELECT_N(sel_n),
    .REG_WRITE(wr), .REG_INDEX(idx), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .MEM_REQ_N(req_n), .MEM_ADDR(addr), .MEM_FAULT_EVENT(ev), .MEM_ACK_N(ack_n),
    .FAULT_N(flt_n), .RAS_N(ras_n), .CAS_N(cas_n), .WRITE_EN_N(we_n),
    .READ_EN_N(re_n), .DRAM_CTL_OE(oe));
  drc_dram_model drc_dram_model_inst (.clock(clk), .rstn(rstn), .ras_n(ras_n),
    .cas_n(cas_n), .oe_n(re_n), .count(cnt), .gap(gap));
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one select assertion per access, held five cycles, and for a read until DATA_OE answers
  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d);
    sel_n = 1'b0;
    wr = w;
    idx = i;
    din = d;
    cyc(5);
    for (k = 0; !w && doe !== 1'b1 && k < 20; k++) cyc(1);
    if (k == 20) begin
      fails++;
      stop_test();
    end
    rd = dout;
    sel_n = 1'b1;
    cyc(4);
  endtask
  task automatic wait_low(input int which);
    for (k = 0; (which ? flt_n : ack_n) !== 1'b0 && k < 60; k++) cyc(1);
    if (k == 60) begin
      fails++;
      stop_test();
    end
  endtask
  initial begin
    cyc(4);
    rstn = 1'b1;
    cyc(2);
    acc(1'b0, drc_pkg::REG_RUN_CONTROL, 8'h00);
    `CHK("run", 8'h00, rd)
    `CHK("ctl_oe", 1'b0, oe)
    req_n = 1'b0;
    acc(1'b0, drc_pkg::REG_REFRESH_INTERVAL, 8'h00);
    `CHK("quiet read", 8'h00, rd)
    `CHK("quiet ack", 1'b1, ack_n)
    req_n = 1'b1;
    acc(1'b1, drc_pkg::REG_RUN_CONTROL, 8'hfe);
    acc(1'b0, drc_pkg::REG_RUN_CONTROL, 8'h00);
    `CHK("upper bits", 8'h00, rd)
    acc(1'b1, drc_pkg::REG_REFRESH_INTERVAL, RI);
    acc(1'b1, drc_pkg::REG_RUN_CONTROL, 8'hff);
    acc(1'b0, drc_pkg::REG_RUN_CONTROL, 8'h00);
    `CHK("run set", 8'h01, rd)
    `CHK("ctl_oe", 1'b1, oe)
    cyc(30);
    `CHK("refresh gap", RI * 8'h04 + 8'h01, gap)
    req_n = 1'b0;
    wait_low(0);
    `CHK("mem ack", 1'b0, ack_n)
    req_n = 1'b1;
    cyc(6);
    `CHK("ack release", 1'b1, ack_n)
    ev = 1'b1;
    wait_low(1);
    `CHK("fault out", 1'b0, flt_n)
    ev = 1'b0;
    addr = 24'h123456;
    acc(1'b1, drc_pkg::REG_FAULT_ADDR0, 8'hff);
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, drc_pkg::REG_FAULT_ADDR0 + 4'(i), 8'h00);
      `CHK("fault addr", 24'h5a3c71 >> (8 * i) & 24'hff, {16'h0000, rd})
    end
    acc(1'b0, drc_pkg::REG_FAULT_FLAG, 8'h00);
    `CHK("flag", 8'h80, rd)
    acc(1'b1, drc_pkg::REG_FAULT_FLAG, 8'h00);
    acc(1'b0, drc_pkg::REG_FAULT_FLAG, 8'h00);
    `CHK("flag clear", 8'h00, rd)
    acc(1'b1, drc_pkg::REG_RUN_CONTROL, 8'h00);
    c0 = cnt;
    cyc(40);
    `CHK("refresh stop", c0, cnt)
    `CHK("ctl_oe", 1'b0, oe)
    stop_test();
  end
endmodule
bind drc_ctrl drc_ctrl_checker drc_ctrl_checker_inst (.CLOCK(CLOCK), .RSTN(RSTN),
  .REG_PORT_SELECT_N(REG_PORT_SELECT_N), .REG_WRITE(REG_WRITE), .DATA_OE(DATA_OE),
  .MEM_REQ_N(MEM_REQ_N), .MEM_FAULT_EVENT(MEM_FAULT_EVENT), .MEM_ACK_N(MEM_ACK_N),
  .FAULT_N(FAULT_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WRITE_EN_N(WRITE_EN_N),
  .READ_EN_N(READ_EN_N), .DRAM_CTL_OE(DRAM_CTL_OE));
`default_nettype wire
